// [rtl/cxo_pkg.sv]
// shared constants and types of the transfer, bit and control execution unit
// assumes one clock domain; every file of the unit imports this package
package cxo_pkg;

  // ==========================================================================
  // widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int IO_W   = 6;

  // ==========================================================================
  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ==========================================================================
  // register port indices
  localparam logic [2:0] REG_FLAGS  = 3'h0;
  localparam logic [2:0] REG_Z_LO   = 3'h1;
  localparam logic [2:0] REG_Z_HI   = 3'h2;
  localparam logic [2:0] REG_Z_EXT  = 3'h3;
  localparam logic [2:0] REG_SP_LO  = 3'h4;
  localparam logic [2:0] REG_SP_HI  = 3'h5;
  localparam logic [2:0] REG_STATUS = 3'h6;

  // ==========================================================================
  // values after reset
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] Z_RST     = 16'h0000;
  localparam logic [7:0]  ZEXT_RST  = 8'h00;
  localparam logic [15:0] SP_RST    = 16'h3FFF;

  // ==========================================================================
  // cycle counts; wait counts are the cycles between accept and finish
  localparam int CYC_EXT_LOAD = 3;
  localparam int CYC_POP      = 2;
  localparam int CYC_RMW      = 2;
  localparam int SRAM_EXTRA   = 1;
  localparam logic [1:0] WAIT_EXT_LOAD = 2'(CYC_EXT_LOAD - 2);
  localparam logic [1:0] WAIT_POP      = 2'(CYC_POP - 2);
  localparam logic [1:0] WAIT_RMW      = 2'(CYC_RMW - 2);
  localparam logic [1:0] WAIT_SRAM     = 2'(SRAM_EXTRA - 1);

  // ==========================================================================
  // operations accepted from the decoder
  typedef enum logic [4:0] {
    OP_NOP, OP_EXT_PROG_LOAD, OP_EXT_PROG_LOAD_INC, OP_PROG_STORE, OP_PROG_STORE_INC,
    OP_IO_READ, OP_IO_WRITE, OP_PUSH, OP_POP, OP_EXCHANGE, OP_LOAD_AND_SET,
    OP_LOAD_AND_CLEAR, OP_LOAD_AND_TOGGLE, OP_LOGICAL_SHIFT_LEFT, OP_LOGICAL_SHIFT_RIGHT,
    OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT, OP_SWAP_NIBBLES,
    OP_FLAG_SET, OP_FLAG_CLEAR, OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_BIT_TO_TFLAG,
    OP_TFLAG_TO_BIT, OP_BREAK, OP_SLEEP, OP_WATCHDOG_RESTART
  } cxo_op_e;

  typedef enum logic [2:0] {
    ALU_PASS, ALU_SHL, ALU_SHR, ALU_RLC, ALU_RRC, ALU_ASR, ALU_SWAP, ALU_BIT_LOAD
  } cxo_alu_e;

  typedef enum logic [1:0] {PH_IDLE, PH_WAIT} cxo_phase_e;

endpackage

// [rtl/cxo_alu_if.sv]
// bundle between the execution core and its shift and bit unit
// assumes the core drives operands and the unit answers combinationally
`timescale 1ns/100ps
interface cxo_alu_if;
  import cxo_pkg::*;
  logic [7:0] a;
  logic [2:0] bitsel;
  logic       c_in;
  logic       t_in;
  cxo_alu_e   func;
  logic [7:0] res;
  logic       c_out;
  logic       z_out;
  logic       n_out;
  logic       v_out;
  logic       s_out;
  logic       h_out;

  modport core (output a, bitsel, c_in, t_in, func,
                input  res, c_out, z_out, n_out, v_out, s_out, h_out);
  modport unit (input  a, bitsel, c_in, t_in, func,
                output res, c_out, z_out, n_out, v_out, s_out, h_out);
endinterface

// [rtl/cxo_alu.sv]
// shift, rotate, nibble swap and t-to-bit unit, purely combinational
// assumes the core registers everything that it takes from here
`timescale 1ns/100ps
module cxo_alu (
  cxo_alu_if.unit u
);
  import cxo_pkg::*;

  // ==========================================================================
  // result and flags; carry stays as given unless the function moves it
  always_comb begin
    u.res   = u.a;
    u.c_out = u.c_in;
    u.h_out = u.a[3];
    case (u.func)
      ALU_SHL: begin
        u.res   = {u.a[6:0], 1'b0};
        u.c_out = u.a[7];
      end
      ALU_RLC: begin
        u.res   = {u.a[6:0], u.c_in};
        u.c_out = u.a[7];
      end
      ALU_SHR: begin
        u.res   = {1'b0, u.a[7:1]};
        u.c_out = u.a[0];
      end
      ALU_RRC: begin
        u.res   = {u.c_in, u.a[7:1]};
        u.c_out = u.a[0];
      end
      ALU_ASR: begin
        u.res   = {u.a[7], u.a[7:1]};
        u.c_out = u.a[0];
      end
      ALU_SWAP: begin
        u.res = {u.a[3:0], u.a[7:4]};
      end
      ALU_BIT_LOAD: begin
        u.res           = u.a;
        u.res[u.bitsel] = u.t_in;
      end
      default: begin
        u.res = u.a;
      end
    endcase
    // sign and overflow follow the usual derivation from n and c
    u.n_out = u.res[7];
    u.z_out = (u.res == 8'h00);
    u.v_out = u.n_out ^ u.c_out;
    u.s_out = u.n_out ^ u.v_out;
  end

endmodule

// [rtl/cxo_core.sv]
// execution core for transfer, bit and control operations of an 8-bit cpu
// assumes a decoder presents one operation with its operand values, and
// memories that return read data in the cycle their read strobe is high
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module cxo_core #(
  parameter logic [15:0] SRAM_BASE = 16'h2000
) (
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                op_valid,
  input  wire cxo_pkg::cxo_op_e    op_code,
  input  wire logic [7:0]          op_rd_val,
  input  wire logic [7:0]          op_rr_val,
  input  wire logic [2:0]          op_bit,
  input  wire logic [5:0]          op_io_addr,
  input  wire logic [7:0]          op_io_val,
  output      logic                op_ready,
  output      logic                res_we,
  output      logic [7:0]          res_data,
  output      logic [23:0]         pmem_addr,
  output      logic                pmem_re,
  input  wire logic [7:0]          pmem_rdata,
  output      logic                pmem_we,
  output      logic [15:0]         pmem_wdata,
  output      logic [15:0]         dmem_addr,
  output      logic                dmem_re,
  input  wire logic [7:0]          dmem_rdata,
  output      logic                dmem_we,
  output      logic [7:0]          dmem_wdata,
  output      logic [5:0]          io_addr,
  output      logic                io_we,
  output      logic [7:0]          io_wdata,
  output      logic                break_req,
  output      logic                sleep_req,
  output      logic                wdt_restart,
  input  wire logic [2:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output      logic [7:0]          reg_rdata
);
  import cxo_pkg::*;

  generate
    if (SRAM_BASE == 16'h0000) begin : g_bad_base
      $error("SRAM_BASE must leave room below it for io space");
    end
  endgenerate

  typedef struct packed {
    cxo_phase_e  phase;
    logic [1:0]  cnt;
    cxo_op_e     op;
    logic [7:0]  rd_orig;
    logic [7:0]  flags;
    logic [15:0] zp;
    logic [7:0]  zext;
    logic [15:0] sp;
    logic        ready;
    logic        res_we;
    logic [7:0]  res_data;
    logic [23:0] pmem_addr;
    logic        pmem_re;
    logic        pmem_we;
    logic [15:0] pmem_wdata;
    logic [15:0] dmem_addr;
    logic        dmem_re;
    logic        dmem_we;
    logic [7:0]  dmem_wdata;
    logic [5:0]  io_addr;
    logic        io_we;
    logic [7:0]  io_wdata;
    logic        brk;
    logic        slp;
    logic        watchdog_restart;
    logic [7:0]  reg_rdata;
  } cxo_core_s;

  cxo_core_s s_r;
  cxo_core_s s_nxt;
  cxo_alu_if alu_bus ();

  // ==========================================================================
  // helpers
  // the extra cycle is only known for internal sram; external memory is not
  // modelled, so its timing is not promised
  function automatic logic in_sram(input logic [15:0] addr);
    in_sram = (addr >= SRAM_BASE);
  endfunction

  function automatic logic [7:0] rmw_value(input cxo_op_e op, input logic [7:0] rd,
                                           input logic [7:0] old);
    case (op)
      OP_LOAD_AND_SET:    rmw_value = rd | old;
      OP_LOAD_AND_CLEAR:  rmw_value = (8'hFF - rd) & old;
      OP_LOAD_AND_TOGGLE: rmw_value = rd ^ old;
      default:            rmw_value = rd;                  // exchange
    endcase
  endfunction

  function automatic cxo_alu_e alu_func(input cxo_op_e op);
    case (op)
      OP_LOGICAL_SHIFT_LEFT:  alu_func = ALU_SHL;
      OP_LOGICAL_SHIFT_RIGHT: alu_func = ALU_SHR;
      OP_ROTATE_LEFT_CARRY:   alu_func = ALU_RLC;
      OP_ROTATE_RIGHT_CARRY:  alu_func = ALU_RRC;
      OP_ARITH_SHIFT_RIGHT:   alu_func = ALU_ASR;
      OP_SWAP_NIBBLES:        alu_func = ALU_SWAP;
      OP_TFLAG_TO_BIT:        alu_func = ALU_BIT_LOAD;
      default:                alu_func = ALU_PASS;
    endcase
  endfunction

  // ==========================================================================
  // shift and bit unit works on the operand as presented
  assign alu_bus.a      = op_rd_val;
  assign alu_bus.bitsel = op_bit;
  assign alu_bus.c_in   = s_r.flags[FLAG_C];
  assign alu_bus.t_in   = s_r.flags[FLAG_T];
  assign alu_bus.func   = alu_func(op_code);

  cxo_alu u_alu (
    .u (alu_bus)
  );

  // ==========================================================================
  // next state: register port first, so an operation's update wins a collision
  always_comb begin
    s_nxt            = s_r;
    s_nxt.res_we     = 1'b0;
    s_nxt.pmem_we    = 1'b0;
    s_nxt.dmem_we    = 1'b0;
    s_nxt.io_we      = 1'b0;
    s_nxt.brk        = 1'b0;
    s_nxt.slp        = 1'b0;
    s_nxt.watchdog_restart        = 1'b0;
    s_nxt.reg_rdata  = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        REG_FLAGS: s_nxt.flags     = reg_wdata;
        REG_Z_LO:  s_nxt.zp[7:0]   = reg_wdata;
        REG_Z_HI:  s_nxt.zp[15:8]  = reg_wdata;
        REG_Z_EXT: s_nxt.zext      = reg_wdata;
        REG_SP_LO: s_nxt.sp[7:0]   = reg_wdata;
        REG_SP_HI: s_nxt.sp[15:8]  = reg_wdata;
        default:   s_nxt.zext      = s_r.zext;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_FLAGS:  s_nxt.reg_rdata = s_r.flags;
        REG_Z_LO:   s_nxt.reg_rdata = s_r.zp[7:0];
        REG_Z_HI:   s_nxt.reg_rdata = s_r.zp[15:8];
        REG_Z_EXT:  s_nxt.reg_rdata = s_r.zext;
        REG_SP_LO:  s_nxt.reg_rdata = s_r.sp[7:0];
        REG_SP_HI:  s_nxt.reg_rdata = s_r.sp[15:8];
        REG_STATUS: s_nxt.reg_rdata = {s_r.ready, 2'b00, s_r.op};
        default:    s_nxt.reg_rdata = 8'h00;
      endcase
    end
    case (s_r.phase)
      PH_IDLE: begin
        if (op_valid) begin
          s_nxt.op      = op_code;
          s_nxt.rd_orig = op_rd_val;
          case (op_code)
            OP_EXT_PROG_LOAD, OP_EXT_PROG_LOAD_INC: begin
              s_nxt.pmem_addr = {s_r.zext, s_r.zp};
              s_nxt.pmem_re   = 1'b1;
              s_nxt.cnt       = WAIT_EXT_LOAD;
              s_nxt.phase     = PH_WAIT;
              s_nxt.ready     = 1'b0;
            end
            OP_PROG_STORE, OP_PROG_STORE_INC: begin
              s_nxt.pmem_addr  = {s_r.zext, s_r.zp};
              s_nxt.pmem_we    = 1'b1;
              s_nxt.pmem_wdata = {op_rr_val, op_rd_val};
              if (op_code == OP_PROG_STORE_INC) begin
                s_nxt.zp = s_r.zp + 16'h0002;
              end
            end
            OP_IO_READ: begin
              s_nxt.res_we   = 1'b1;
              s_nxt.res_data = op_io_val;
            end
            OP_IO_WRITE: begin
              s_nxt.io_we    = 1'b1;
              s_nxt.io_addr  = op_io_addr;
              s_nxt.io_wdata = op_rr_val;
            end
            OP_PUSH: begin
              s_nxt.dmem_addr  = s_r.sp;
              s_nxt.dmem_we    = 1'b1;
              s_nxt.dmem_wdata = op_rr_val;
              s_nxt.sp         = s_r.sp - 16'h0001;
              if (in_sram(s_r.sp)) begin
                s_nxt.cnt   = WAIT_SRAM;
                s_nxt.phase = PH_WAIT;
                s_nxt.ready = 1'b0;
              end
            end
            OP_POP, OP_EXCHANGE, OP_LOAD_AND_SET, OP_LOAD_AND_CLEAR, OP_LOAD_AND_TOGGLE: begin
              s_nxt.dmem_addr = (op_code == OP_POP) ? s_r.sp + 16'h0001 : s_r.zp;
              s_nxt.dmem_re   = 1'b1;
              if (op_code == OP_POP) begin
                s_nxt.sp = s_r.sp + 16'h0001;
              end
              s_nxt.cnt   = (op_code == OP_POP) ? WAIT_POP : WAIT_RMW;
              if (in_sram(s_nxt.dmem_addr)) begin
                s_nxt.cnt = s_nxt.cnt + 2'(SRAM_EXTRA);
              end
              s_nxt.phase = PH_WAIT;
              s_nxt.ready = 1'b0;
            end
            OP_LOGICAL_SHIFT_LEFT, OP_ROTATE_LEFT_CARRY, OP_LOGICAL_SHIFT_RIGHT,
            OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT: begin
              s_nxt.res_we        = 1'b1;
              s_nxt.res_data      = alu_bus.res;
              s_nxt.flags[FLAG_C] = alu_bus.c_out;
              s_nxt.flags[FLAG_Z] = alu_bus.z_out;
              s_nxt.flags[FLAG_N] = alu_bus.n_out;
              s_nxt.flags[FLAG_V] = alu_bus.v_out;
              s_nxt.flags[FLAG_S] = alu_bus.s_out;
              if (op_code == OP_LOGICAL_SHIFT_LEFT || op_code == OP_ROTATE_LEFT_CARRY) begin
                s_nxt.flags[FLAG_H] = alu_bus.h_out;
              end
            end
            OP_SWAP_NIBBLES, OP_TFLAG_TO_BIT: begin
              s_nxt.res_we   = 1'b1;
              s_nxt.res_data = alu_bus.res;
            end
            OP_FLAG_SET: begin
              s_nxt.flags[op_bit] = 1'b1;
            end
            OP_FLAG_CLEAR: begin
              s_nxt.flags[op_bit] = 1'b0;
            end
            OP_IO_BIT_SET: begin
              s_nxt.io_we    = 1'b1;
              s_nxt.io_addr  = op_io_addr;
              s_nxt.io_wdata = op_io_val | (8'h01 << op_bit);
            end
            OP_IO_BIT_CLEAR: begin
              s_nxt.io_we    = 1'b1;
              s_nxt.io_addr  = op_io_addr;
              s_nxt.io_wdata = op_io_val & ~(8'h01 << op_bit);
            end
            OP_BIT_TO_TFLAG: begin
              s_nxt.flags[FLAG_T] = op_rr_val[op_bit];
            end
            OP_BREAK:            s_nxt.brk = 1'b1;
            OP_SLEEP:            s_nxt.slp = 1'b1;
            OP_WATCHDOG_RESTART: s_nxt.watchdog_restart = 1'b1;
            default:             s_nxt.op  = op_code;
          endcase
        end
      end
      PH_WAIT: begin
        if (s_r.cnt != 2'h0) begin
          s_nxt.cnt = s_r.cnt - 2'h1;
        end else begin
          // finish: read data is sampled while its strobe is still high
          s_nxt.phase = PH_IDLE;
          s_nxt.ready = 1'b1;
          case (s_r.op)
            OP_EXT_PROG_LOAD, OP_EXT_PROG_LOAD_INC: begin
              s_nxt.pmem_re  = 1'b0;
              s_nxt.res_we   = 1'b1;
              s_nxt.res_data = pmem_rdata;
              if (s_r.op == OP_EXT_PROG_LOAD_INC) begin
                s_nxt.zp = s_r.zp + 16'h0001;
              end
            end
            OP_POP: begin
              s_nxt.dmem_re  = 1'b0;
              s_nxt.res_we   = 1'b1;
              s_nxt.res_data = dmem_rdata;
            end
            OP_EXCHANGE, OP_LOAD_AND_SET, OP_LOAD_AND_CLEAR, OP_LOAD_AND_TOGGLE: begin
              s_nxt.dmem_re    = 1'b0;
              s_nxt.res_we     = 1'b1;
              s_nxt.res_data   = dmem_rdata;
              s_nxt.dmem_we    = 1'b1;
              s_nxt.dmem_wdata = rmw_value(s_r.op, s_r.rd_orig, dmem_rdata);
            end
            default: s_nxt.dmem_re = 1'b0;
          endcase
        end
      end
      default: s_nxt.phase = PH_IDLE;
    endcase
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_r       <= '0;
      s_r.phase <= PH_IDLE;
      s_r.op    <= OP_NOP;
      s_r.flags <= FLAGS_RST;
      s_r.zp    <= Z_RST;
      s_r.zext  <= ZEXT_RST;
      s_r.sp    <= SP_RST;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign op_ready    = s_r.ready;
  assign res_we      = s_r.res_we;
  assign res_data    = s_r.res_data;
  assign pmem_addr   = s_r.pmem_addr;
  assign pmem_re     = s_r.pmem_re;
  assign pmem_we     = s_r.pmem_we;
  assign pmem_wdata  = s_r.pmem_wdata;
  assign dmem_addr   = s_r.dmem_addr;
  assign dmem_re     = s_r.dmem_re;
  assign dmem_we     = s_r.dmem_we;
  assign dmem_wdata  = s_r.dmem_wdata;
  assign io_addr     = s_r.io_addr;
  assign io_we       = s_r.io_we;
  assign io_wdata    = s_r.io_wdata;
  assign break_req   = s_r.brk;
  assign sleep_req   = s_r.slp;
  assign wdt_restart = s_r.watchdog_restart;
  assign reg_rdata   = s_r.reg_rdata;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  logic take;
  logic pop_sram;
  logic z_sram;
  assign take     = op_valid && op_ready && !reg_wr;
  // memory region of the pending access, so the antecedents stay short
  assign pop_sram = in_sram(s_r.sp + 16'h0001);
  assign z_sram   = in_sram(s_r.zp);

  sequence rmw_read;
    dmem_re && !op_ready;
  endsequence
  sequence rmw_done;
    dmem_we && res_we && op_ready && res_data == $past(dmem_rdata);
  endsequence

  a_ext_load_three: assert property (take && op_code == OP_EXT_PROG_LOAD_INC |=>
    (pmem_re && !op_ready) [*2] ##1 (res_we && op_ready && res_data == $past(pmem_rdata)))
    else $error("extended program load timing or data wrong");
  a_store_step_two: assert property (take && op_code == OP_PROG_STORE_INC |=>
    pmem_we && pmem_wdata == {$past(op_rr_val), $past(op_rd_val)} &&
    s_r.zp == $past(s_r.zp) + 16'h0002)
    else $error("program store did not advance pointer by two");
  a_io_write_once: assert property (take && op_code == OP_IO_WRITE |=>
    io_we && op_ready && io_wdata == $past(op_rr_val) && s_r.flags == $past(s_r.flags))
    else $error("io write wrong");
  a_pop_two_cycles: assert property (take && op_code == OP_POP && !pop_sram |=>
    (dmem_re && !op_ready) ##1 (res_we && op_ready && s_r.flags == $past(s_r.flags, 2)))
    else $error("pop did not finish in two cycles");
  a_pop_sram_extra: assert property (take && op_code == OP_POP && pop_sram |=>
    (dmem_re && !op_ready) [*2] ##1 (res_we && op_ready))
    else $error("sram pop lacks the extra cycle");
  a_load_set_or: assert property (take && op_code == OP_LOAD_AND_SET && !z_sram |=>
    rmw_read ##1 (rmw_done and dmem_wdata == ($past(op_rd_val, 2) | $past(dmem_rdata))))
    else $error("load and set wrote wrong value");
  a_load_clear_and: assert property (take && op_code == OP_LOAD_AND_CLEAR && !z_sram |=>
    rmw_read ##1 (rmw_done and dmem_wdata == (~$past(op_rd_val, 2) & $past(dmem_rdata))))
    else $error("load and clear wrote wrong value");
  a_load_toggle_xor: assert property (take && op_code == OP_LOAD_AND_TOGGLE && !z_sram |=>
    rmw_read ##1 (rmw_done and dmem_wdata == ($past(op_rd_val, 2) ^ $past(dmem_rdata))))
    else $error("load and toggle wrote wrong value");
  a_shift_left_carry: assert property (take && op_code == OP_LOGICAL_SHIFT_LEFT |=>
    res_we && res_data == {$past(op_rd_val[6:0]), 1'b0} &&
    s_r.flags[FLAG_C] == $past(op_rd_val[7]))
    else $error("left shift result or carry wrong");
  a_arith_keeps_sign: assert property (take && op_code == OP_ARITH_SHIFT_RIGHT |=>
    res_data == {$past(op_rd_val[7]), $past(op_rd_val[7:1])} &&
    s_r.flags[FLAG_C] == $past(op_rd_val[0]))
    else $error("arithmetic right shift wrong");
  a_io_bit_set: assert property (take && op_code == OP_IO_BIT_SET |=>
    io_we && io_wdata == ($past(op_io_val) | (8'h01 << $past(op_bit))) &&
    s_r.flags == $past(s_r.flags))
    else $error("io bit set wrong");
  a_bit_to_t: assert property (take && op_code == OP_BIT_TO_TFLAG |=>
    s_r.flags[FLAG_T] == $past(op_rr_val[op_bit]) && op_ready)
    else $error("t flag not loaded from bit");
  a_flag_set_only: assert property (take && op_code == OP_FLAG_SET |=>
    s_r.flags == ($past(s_r.flags) | (8'h01 << $past(op_bit))))
    else $error("flag set touched other flags");
  a_sleep_no_flags: assert property (take && op_code == OP_SLEEP |=>
    sleep_req && op_ready && s_r.flags == $past(s_r.flags) ##1 !sleep_req)
    else $error("sleep request wrong");
  a_shift_sign_rule: assert property ($past(take) && res_we && op_ready &&
    $past(op_code) inside {OP_LOGICAL_SHIFT_RIGHT, OP_ROTATE_RIGHT_CARRY} |->
    s_r.flags[FLAG_S] == (s_r.flags[FLAG_N] ^ s_r.flags[FLAG_V]) &&
    s_r.flags[FLAG_V] == (s_r.flags[FLAG_N] ^ s_r.flags[FLAG_C]))
    else $error("sign or overflow derivation wrong");

endmodule

// [dv/cxo_mem_model.sv]
// data and program memory beside the core
// assumes registered strobes and answers while the strobe is high
`timescale 1ns/100ps
module cxo_mem_model (
  input  wire logic        clock,
  input  wire logic [15:0] dmem_addr,
  input  wire logic        dmem_re,
  input  wire logic        dmem_we,
  input  wire logic [7:0]  dmem_wdata,
  output      logic [7:0]  dmem_rdata,
  input  wire logic [23:0] pmem_addr,
  input  wire logic        pmem_re,
  output      logic [7:0]  pmem_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last_r = 8'h00;
  // ===========================================================================
  // idle buses show the inverse of the last data memory read, so stale data never matches
  assign dmem_rdata = dmem_re ? mem[dmem_addr[7:0]] : ~last_r;
  assign pmem_rdata = pmem_re ? pmem_addr[7:0] ^ 8'hA5 : ~last_r;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'h5A;
  always @(posedge clock) begin
    if (dmem_re) last_r <= mem[dmem_addr[7:0]];
    if (dmem_we) mem[dmem_addr[7:0]] <= dmem_wdata;
  end
endmodule

// [dv/cxo_core_bench.sv]
// self-checking bench: table of operations, then flags, pointer and sram timing
// assumes the package, core and memory model are compiled first
`timescale 1ns/100ps
module cxo_core_bench;
  import cxo_pkg::*;
  typedef struct {cxo_op_e op; logic [7:0] rd; logic [7:0] e; int n;} cxo_row_s;
  logic clock = 1'b0, reset = 1'b1, op_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  cxo_op_e op_code = OP_NOP;
  logic [7:0] op_rd_val = 8'h00, op_rr_val = 8'h00, reg_wdata = 8'h00, got, rdat;
  logic [2:0] op_bit = 3'h0, reg_addr = 3'h0;
  logic op_ready, res_we, pmem_re, pmem_we, dmem_re, dmem_we, io_we, brk, slp, watchdog_restart;
  logic [5:0] io_addr;
  logic [7:0] res_data, pmem_rdata, dmem_rdata, dmem_wdata, io_wdata, reg_rdata;
  logic [15:0] pmem_wdata, dmem_addr, pw;
  logic [23:0] pmem_addr;
  int bad_count = 0, samples_checked = 0, cyc = 0, n;
  // chained rows: each read-modify-write sees the byte the previous one left
  cxo_row_s rows [21] = '{'{OP_LOGICAL_SHIFT_LEFT, 8'h81, 8'h02, 1},
    '{OP_LOGICAL_SHIFT_RIGHT, 8'h81, 8'h40, 1}, '{OP_ARITH_SHIFT_RIGHT, 8'h81, 8'hC0, 1},
    '{OP_SWAP_NIBBLES, 8'h81, 8'h18, 1}, '{OP_ROTATE_LEFT_CARRY, 8'h81, 8'h03, 1},
    '{OP_ROTATE_RIGHT_CARRY, 8'h81, 8'hC0, 1}, '{OP_IO_READ, 8'h81, 8'h66, 1},
    '{OP_IO_WRITE, 8'h81, 8'h71, 1}, '{OP_IO_BIT_SET, 8'h81, 8'h67, 1},
    '{OP_IO_BIT_CLEAR, 8'h81, 8'h66, 1}, '{OP_LOAD_AND_SET, 8'h81, 8'h5A, 2},
    '{OP_LOAD_AND_CLEAR, 8'h81, 8'hDB, 2}, '{OP_LOAD_AND_TOGGLE, 8'h81, 8'h5A, 2},
    '{OP_EXCHANGE, 8'h81, 8'hDB, 2}, '{OP_PUSH, 8'hCC, 8'h3C, 2}, '{OP_POP, 8'h00, 8'h3C, 3},
    '{OP_BREAK, 8'h00, 8'h04, 1}, '{OP_SLEEP, 8'h00, 8'h02, 1},
    '{OP_WATCHDOG_RESTART, 8'h00, 8'h01, 1}, '{OP_NOP, 8'h00, 8'h00, 1},
    '{OP_EXT_PROG_LOAD, 8'h00, 8'hA5, 3}};
  cxo_core i_dut (.clock, .reset, .op_valid, .op_code, .op_rd_val, .op_rr_val, .op_bit,
    .op_io_addr(6'h05), .op_io_val(8'h66), .op_ready, .res_we, .res_data, .pmem_addr,
    .pmem_re, .pmem_rdata, .pmem_we, .pmem_wdata, .dmem_addr, .dmem_re, .dmem_rdata,
    .dmem_we, .dmem_wdata, .io_addr, .io_we, .io_wdata, .break_req(brk), .sleep_req(slp),
    .wdt_restart(watchdog_restart), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  cxo_mem_model i_mem (.clock, .dmem_addr, .dmem_re, .dmem_we, .dmem_wdata, .dmem_rdata,
    .pmem_addr, .pmem_re, .pmem_rdata);
  initial forever #25 clock = ~clock;
  // ===========================================================================
  // one operation; n counts cycles from the accept edge until ready again
  task automatic run(input cxo_op_e op, input logic [7:0] rd, input logic [2:0] b);
    @(posedge clock);
    op_code <= op;
    {op_rd_val, op_rr_val, op_bit, op_valid} <= {rd, rd ^ 8'hF0, b, 1'b1};
    @(posedge clock);
    op_valid <= 1'b0;
    // a fresh result per operation, so a missing strobe cannot reuse the last one
    got = 8'h00;
    for (n = 1; n < 9; n++) begin
      #1;
      if (res_we) got = res_data;
      else if (dmem_we) got = dmem_wdata;
      else if (io_we) got = io_wdata;
      else if (brk || slp || watchdog_restart) got = {5'h00, brk, slp, watchdog_restart};
      if (pmem_we) pw = pmem_wdata;
      if (op_ready) break;
      @(posedge clock);
    end
  endtask
  task automatic rw(input logic wr, input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {wr, !wr, a, d};
    @(posedge clock);
    {reg_wr, reg_rd} <= 2'h0;
    #1 rdat = reg_rdata;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, well past the hundred or so cycles the tests need
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    #1 chk(16'(op_ready), 16'h0001);
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].rd, 3'h0);
      chk(16'(got), 16'(rows[i].e));
      chk(16'(n), 16'(rows[i].n));
    end
    chk(16'(io_addr), 16'h0005);
    rw(1'b0, REG_FLAGS, 8'h00);
    chk(16'(rdat), 16'h0015);
    run(OP_FLAG_SET, 8'h00, 3'h5);
    run(OP_FLAG_CLEAR, 8'h00, 3'h0);
    run(OP_BIT_TO_TFLAG, 8'hF4, 3'h2);
    rw(1'b0, REG_FLAGS, 8'h00);
    chk(16'(rdat), 16'h0074);
    run(OP_TFLAG_TO_BIT, 8'h00, 3'h7);
    chk(16'(got), 16'h0080);
    run(OP_EXT_PROG_LOAD_INC, 8'h00, 3'h0);
    chk(16'(got), 16'h00A5);
    chk(16'(n), 16'h0003);
    run(OP_PROG_STORE_INC, 8'h12, 3'h0);
    chk(pw, 16'hE212);
    run(OP_PROG_STORE, 8'h34, 3'h0);
    chk(pw, 16'hC434);
    chk(16'(pmem_addr), 16'h0003);
    rw(1'b0, REG_Z_LO, 8'h00);
    chk(16'(rdat), 16'h0003);
    rw(1'b1, REG_Z_HI, 8'h20);
    run(OP_LOAD_AND_SET, 8'h00, 3'h0);
    chk(16'(n), 16'h0003);
    chk(dmem_addr, 16'h2003);
    rw(1'b0, REG_STATUS, 8'h00);
    chk(16'(rdat), 16'({3'h4, OP_LOAD_AND_SET}));
    // stack below the sram base: no extra cycle on either side
    rw(1'b1, REG_SP_HI, 8'h00);
    run(OP_PUSH, 8'h0F, 3'h0);
    chk(16'(n), 16'h0001);
    run(OP_POP, 8'h00, 3'h0);
    chk(16'(got), 16'h00FF);
    chk(16'(n), 16'h0002);
    rw(1'b0, 3'h7, 8'h00);
    chk(16'(rdat), 16'h0000);
    // second reset in mid-run must bring the stack pointer back
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rw(1'b0, REG_SP_HI, 8'h00);
    chk(16'(rdat), 16'(SP_RST[15:8]));
    tally_and_finish;
  end
endmodule
